// [logic/aucp_interp.sv]
// ASCII command interpreter: line parser, checksum check, response framer
`timescale 1ns/1ps
`default_nettype none
module aucp_interp
   import aucp_pkg::*;
#(
   parameter logic [NAME_MAX-1:0][7:0] ACK_NAME = ACK_NAME_DEF,
   parameter logic [3:0] ACK_LEN = ACK_LEN_DEF
)(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_valid_in,
   input wire logic mode_enter_in,
   input wire logic tx_ready_in,
   input wire logic exec_valid_in,
   input wire aucp_exec_t exec_in,
   input wire logic [7:0] val_byte_in,
   input wire logic val_valid_in,
   input wire logic val_last_in,
   output logic [7:0] tx_byte_out,
   output logic tx_valid_out,
   output logic val_ready_out,
   output logic req_valid_out,
   output aucp_req_t req_out,
   output logic [7:0] param_char_out,
   output logic [6:0] param_idx_out,
   output logic param_valid_out,
   output logic busy_out
);
   aucp_regs_t q;
   aucp_regs_t n;

   logic [7:0] rx_crc_seed;
   logic [7:0] rx_crc_next;
   logic [7:0] tx_crc_seed;
   logic [7:0] tx_crc_next;
   logic [7:0] tx_load_byte;
   logic [2:0][7:0] crc_asc;
   logic [1:0] crc_ndig;
   logic slot;

   // A new line restarts the running checksum from the seed
   assign rx_crc_seed = (q.st == ST_RECV) ? q.rx_crc : CRC_SEED;

   aucp_crc8 u_rx_crc (
      .crc_in(rx_crc_seed),
      .byte_in(rx_byte_in),
      .crc_out(rx_crc_next)
   );

   assign tx_crc_seed = (q.st == ST_HASH) ? CRC_SEED : q.tx_crc;

   aucp_crc8 u_tx_crc (
      .crc_in(tx_crc_seed),
      .byte_in(tx_load_byte),
      .crc_out(tx_crc_next)
   );

   aucp_dec3 u_dec (
      .val_in(q.tx_crc),
      .asc_out(crc_asc),
      .ndig_out(crc_ndig)
   );

   // Transmit slot is free when nothing waits or the sink takes it now
   assign slot = !q.tx_valid || tx_ready_in;

   // Byte that the current transmit state would put on the wire
   always_comb begin
      case (q.st)
         ST_HASH: tx_load_byte = CH_HASH;
         ST_NAME: tx_load_byte = q.req.name[q.idx];
         ST_C1: tx_load_byte = CH_COMMA;
         ST_STAT: tx_load_byte = CH_ZERO + {4'h0, q.status};
         ST_C2: tx_load_byte = CH_COMMA;
         ST_VAL: tx_load_byte = val_byte_in;
         ST_C3: tx_load_byte = CH_COMMA;
         ST_CRC: tx_load_byte = crc_asc[q.idx[1:0]];
         ST_CR: tx_load_byte = CH_CR;
         default: tx_load_byte = CH_CR;
      endcase
   end

   always_comb begin
      logic is_digit;
      logic is_lower;
      logic is_num_sym;
      logic is_blank;
      logic [11:0] acc;
      logic [3:0] own;
      logic [3:0] fin;
      logic crc_bad;
      is_digit = (rx_byte_in >= CH_ZERO) && (rx_byte_in <= CH_NINE);
      is_lower = (rx_byte_in >= CH_LC_A) && (rx_byte_in <= CH_LC_Z);
      is_num_sym = (rx_byte_in == CH_DOT) || (rx_byte_in == CH_PLUS) || (rx_byte_in == CH_MINUS);
      is_blank = (rx_byte_in == CH_SP) || (rx_byte_in == CH_HT);
      acc = (q.fld_val * 12'd10) + {4'h0, rx_byte_in - CH_ZERO};
      own = q.req.name_bad ? STS_UNKNOWN : (q.syn_bad ? STS_BADPARAM : STS_OK);
      fin = exec_in.status;
      crc_bad = (q.commas == 7'h00) || q.fld_empty || !q.fld_num_ok ||
                (q.fld_val[11:8] != 4'h0) || (q.fld_val[7:0] != q.crc_at_comma);
      n = q;
      n.req_valid = 1'b0;
      n.param_valid = 1'b0;
      if (q.tx_valid && tx_ready_in) begin
         n.tx_valid = 1'b0;
      end
      case (q.st)
         ST_IDLE, ST_DROP: begin
            if (mode_enter_in && (q.st == ST_IDLE)) begin
               n.req.name = ACK_NAME;
               n.req.name_len = ACK_LEN;
               n.ack = 1'b1;
               n.has_vals = 1'b0;
               n.st = ST_HASH;
            end else if (rx_valid_in && (rx_byte_in != CH_CR) &&
                         ((rx_byte_in == CH_DOLLAR) || (q.st == ST_IDLE))) begin
               // Only a dollar leaves the dropped state
               n.st = ST_RECV;
               n.no_start = (rx_byte_in != CH_DOLLAR);
               n.len = 7'h01;
               n.rx_crc = rx_crc_next;
               n.commas = 7'h00;
               // Stale bytes would confuse a full-width name compare
               n.req.name = '0;
               n.req.name_len = 4'h0;
               n.req.name_bad = 1'b0;
               n.syn_bad = 1'b0;
               n.fld_val = 12'h000;
               n.fld_num_ok = 1'b1;
               n.fld_empty = 1'b1;
               n.fld_bad = 1'b0;
               n.ack = 1'b0;
            end
         end
         ST_RECV: begin
            if (rx_valid_in) begin
               if (rx_byte_in == CH_CR) begin
                  n.has_vals = 1'b0;
                  n.idx = 4'h0;
                  if (q.no_start) begin
                     n.status = STS_INVALID;
                     n.req.name_len = 4'h0;
                     n.st = ST_HASH;
                  end else if (crc_bad) begin
                     n.status = STS_CRC;
                     n.req.name_len = 4'h0;
                     n.st = ST_HASH;
                  end else begin
                     // Executor owns name lookup, count and side effects
                     n.req.param_cnt = q.commas - 7'h01;
                     n.req_valid = 1'b1;
                     n.st = ST_EXEC;
                  end
               end else if (q.len == (MAX_LEN - 7'h01)) begin
                  n.st = ST_DROP;
               end else begin
                  n.len = q.len + 7'h01;
                  n.rx_crc = rx_crc_next;
                  if (rx_byte_in == CH_COMMA) begin
                     n.commas = q.commas + 7'h01;
                     n.crc_at_comma = rx_crc_next;
                     if (q.commas == 7'h00) begin
                        if (q.req.name_len == 4'h0) begin
                           n.req.name_bad = 1'b1;
                        end
                     end else if (q.fld_empty || q.fld_bad) begin
                        n.syn_bad = 1'b1;
                     end
                     n.fld_val = 12'h000;
                     n.fld_num_ok = 1'b1;
                     n.fld_empty = 1'b1;
                     n.fld_bad = 1'b0;
                  end else if (q.commas == 7'h00) begin
                     if (is_lower && (q.req.name_len != NAME_MAX[3:0])) begin
                        n.req.name[q.req.name_len] = rx_byte_in;
                        n.req.name_len = q.req.name_len + 4'h1;
                     end else begin
                        n.req.name_bad = 1'b1;
                     end
                  end else if (q.fld_empty && is_blank) begin
                     n.fld_empty = 1'b1;
                  end else begin
                     n.fld_empty = 1'b0;
                     n.param_char = rx_byte_in;
                     n.param_idx = q.commas - 7'h01;
                     n.param_valid = 1'b1;
                     if (is_digit) begin
                        // Stop accumulating above 255 so an overlong checksum field cannot wrap
                        n.fld_val = (q.fld_val[11:8] != 4'h0) ? q.fld_val : acc;
                     end else begin
                        n.fld_num_ok = 1'b0;
                     end
                     if (!(is_digit || is_lower || is_num_sym)) begin
                        n.fld_bad = 1'b1;
                     end
                  end
               end
            end
         end
         ST_EXEC: begin
            if (exec_valid_in) begin
               if ((own != STS_OK) && ((fin == STS_OK) || (own < fin))) begin
                  fin = own;
               end
               n.status = fin;
               if ((fin == STS_INVALID) || (fin == STS_CRC) || (fin == STS_UNKNOWN)) begin
                  n.req.name_len = 4'h0;
               end
               n.has_vals = exec_in.has_vals;
               n.st = ST_HASH;
            end
         end
         ST_VAL: begin
            if (q.val_ready && val_valid_in) begin
               n.tx_byte = tx_load_byte;
               n.tx_valid = 1'b1;
               n.tx_crc = tx_crc_next;
               if (val_last_in) begin
                  n.st = ST_C3;
               end
            end
         end
         ST_HASH, ST_NAME, ST_C1, ST_STAT, ST_C2, ST_C3, ST_CRC, ST_CR: begin
            if (slot) begin
               n.tx_byte = tx_load_byte;
               n.tx_valid = 1'b1;
               if ((q.st != ST_CRC) && (q.st != ST_CR)) begin
                  n.tx_crc = tx_crc_next;
               end
               n.idx = 4'h0;
               case (q.st)
                  ST_HASH: begin
                     n.st = (q.req.name_len == 4'h0) ? ST_C1 : ST_NAME;
                  end
                  ST_NAME: begin
                     if (q.idx == (q.req.name_len - 4'h1)) begin
                        n.st = ST_C1;
                     end else begin
                        n.idx = q.idx + 4'h1;
                     end
                  end
                  ST_C1: begin
                     n.st = q.ack ? ST_CRC : ST_STAT;
                  end
                  ST_STAT: begin
                     n.st = ST_C2;
                  end
                  ST_C2: begin
                     n.st = q.has_vals ? ST_VAL : ST_CRC;
                  end
                  ST_C3: begin
                     n.st = ST_CRC;
                  end
                  ST_CRC: begin
                     if (q.idx == {2'b00, crc_ndig - 2'd1}) begin
                        n.st = ST_CR;
                     end else begin
                        n.idx = q.idx + 4'h1;
                     end
                  end
                  default: begin
                     n.st = ST_IDLE;
                  end
               endcase
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      // Registered ready: one value byte per free transmit slot
      n.val_ready = (n.st == ST_VAL) && !n.tx_valid;
      // Busy also covers a closing byte still waiting for the sink
      n.busy = (n.st != ST_IDLE) || n.tx_valid;
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         q <= '0;
         q.st <= ST_IDLE;
      end else begin
         q <= n;
      end
   end

   assign tx_byte_out = q.tx_byte;
   assign tx_valid_out = q.tx_valid;
   assign val_ready_out = q.val_ready;
   assign req_valid_out = q.req_valid;
   assign req_out = q.req;
   assign param_char_out = q.param_char;
   assign param_idx_out = q.param_idx;
   assign param_valid_out = q.param_valid;
   assign busy_out = q.busy;
endmodule
`default_nettype wire

// [logic/aucp_pkg.sv]
// Package: constants and carrier types for the ASCII command interpreter
`default_nettype none
package aucp_pkg;
   // Character codes
   localparam logic [7:0] CH_DOLLAR = 8'h24;
   localparam logic [7:0] CH_HASH = 8'h23;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_HT = 8'h09;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_NINE = 8'h39;
   localparam logic [7:0] CH_LC_A = 8'h61;
   localparam logic [7:0] CH_LC_Z = 8'h7A;
   localparam logic [7:0] CH_DOT = 8'h2E;
   localparam logic [7:0] CH_PLUS = 8'h2B;
   localparam logic [7:0] CH_MINUS = 8'h2D;

   // Checksum
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_SEED = 8'hFF;

   // Line limits
   localparam logic [6:0] MAX_LEN = 7'h64;
   localparam int NAME_MAX = 12;

   // Status codes
   localparam logic [3:0] STS_OK = 4'h0;
   localparam logic [3:0] STS_INVALID = 4'h1;
   localparam logic [3:0] STS_CRC = 4'h2;
   localparam logic [3:0] STS_UNKNOWN = 4'h3;
   localparam logic [3:0] STS_NPARAM = 4'h4;
   localparam logic [3:0] STS_BADPARAM = 4'h5;

   // Acknowledge name for entering the command mode; value is arbitrary
   localparam logic [NAME_MAX-1:0][7:0] ACK_NAME_DEF = 96'h0000_0000_0045_444F_4D44_4D43;
   localparam logic [3:0] ACK_LEN_DEF = 4'h7;

   typedef enum logic [12:0] {
      ST_IDLE = 13'h0001,
      ST_RECV = 13'h0002,
      ST_DROP = 13'h0004,
      ST_EXEC = 13'h0008,
      ST_HASH = 13'h0010,
      ST_NAME = 13'h0020,
      ST_C1 = 13'h0040,
      ST_STAT = 13'h0080,
      ST_C2 = 13'h0100,
      ST_VAL = 13'h0200,
      ST_C3 = 13'h0400,
      ST_CRC = 13'h0800,
      ST_CR = 13'h1000
   } aucp_state_t;

   typedef struct packed {
      logic [NAME_MAX-1:0][7:0] name;
      logic [3:0] name_len;
      logic [6:0] param_cnt;
      logic name_bad;
   } aucp_req_t;

   typedef struct packed {
      logic [3:0] status;
      logic has_vals;
   } aucp_exec_t;

   typedef struct packed {
      aucp_state_t st;
      logic [6:0] len;
      logic [7:0] rx_crc;
      logic [7:0] crc_at_comma;
      logic [11:0] fld_val;
      logic fld_num_ok;
      logic fld_empty;
      logic fld_bad;
      logic [6:0] commas;
      logic no_start;
      logic syn_bad;
      logic ack;
      aucp_req_t req;
      logic [3:0] status;
      logic has_vals;
      logic [3:0] idx;
      logic [7:0] tx_crc;
      logic [7:0] tx_byte;
      logic tx_valid;
      logic val_ready;
      logic req_valid;
      logic [7:0] param_char;
      logic [6:0] param_idx;
      logic param_valid;
      logic busy;
   } aucp_regs_t;
endpackage
`default_nettype wire

// [logic/aucp_crc8.sv]
// One-byte step of the 8-bit checksum
`timescale 1ns/1ps
`default_nettype none
module aucp_crc8
   import aucp_pkg::*;
(
   input wire logic [7:0] crc_in,
   input wire logic [7:0] byte_in,
   output logic [7:0] crc_out
);
   always_comb begin
      logic [7:0] c;
      c = crc_in ^ byte_in;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      crc_out = c;
   end
endmodule
`default_nettype wire

// [logic/aucp_dec3.sv]
// Byte to decimal ASCII digits, leading zeros suppressed
`timescale 1ns/1ps
`default_nettype none
module aucp_dec3
   import aucp_pkg::*;
(
   input wire logic [7:0] val_in,
   output logic [2:0][7:0] asc_out,
   output logic [1:0] ndig_out
);
   always_comb begin
      logic [7:0] h;
      logic [7:0] t;
      logic [7:0] o;
      h = val_in / 8'd100;
      t = (val_in / 8'd10) % 8'd10;
      o = val_in % 8'd10;
      asc_out = '0;
      // Slot 0 is the first digit on the wire
      if (h != 8'h00) begin
         asc_out[0] = CH_ZERO + h;
         asc_out[1] = CH_ZERO + t;
         asc_out[2] = CH_ZERO + o;
         ndig_out = 2'd3;
      end else if (t != 8'h00) begin
         asc_out[0] = CH_ZERO + t;
         asc_out[1] = CH_ZERO + o;
         ndig_out = 2'd2;
      end else begin
         asc_out[0] = CH_ZERO + o;
         ndig_out = 2'd1;
      end
   end
endmodule
`default_nettype wire

// [bench/aucp_interp_props.sv]
// Port-level checker for the ASCII command interpreter
`timescale 1ns/1ps
`default_nettype none
module aucp_interp_props
   import aucp_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_valid_in,
   input wire logic mode_enter_in,
   input wire logic tx_ready_in,
   input wire logic exec_valid_in,
   input wire logic [7:0] tx_byte_out,
   input wire logic tx_valid_out,
   input wire logic req_valid_out,
   input wire logic busy_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   // High while the next accepted byte opens a new response
   logic first_q;
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         first_q <= 1'b1;
      end else if (tx_valid_out && tx_ready_in) begin
         first_q <= (tx_byte_out == CH_CR);
      end
   end

   chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_byte_out)) else $error("tx byte changed while stalled");
   chk_resp_hash: assert property (tx_valid_out && first_q |->
      tx_byte_out == CH_HASH) else $error("response does not open with hash");
   chk_req_pulse: assert property (req_valid_out |=> !req_valid_out)
      else $error("request longer than one cycle");
   chk_req_after_cr: assert property (req_valid_out |->
      $past(rx_valid_in) && $past(rx_byte_in) == CH_CR) else $error("request without CR");
   chk_exec_start: assert property (exec_valid_in |-> ##2
      tx_valid_out && tx_byte_out == CH_HASH) else $error("response late after exec");
   chk_ack_start: assert property (mode_enter_in && !busy_out |->
      ##[1:3] (tx_valid_out && tx_byte_out == CH_HASH)) else $error("no mode acknowledge");
   chk_end_idle: assert property (tx_valid_out && tx_ready_in && tx_byte_out == CH_CR
      |=> !busy_out && !tx_valid_out) else $error("output continues after CR");
   chk_tx_busy: assert property ($fell(busy_out) |->
      $past(tx_valid_out && tx_ready_in && tx_byte_out == CH_CR))
      else $error("busy ended before the closing CR");
   chk_reset_quiet: assert property ($fell(srst_in) |->
      !busy_out && !tx_valid_out && !req_valid_out) else $error("outputs active after reset");

   cover property (req_valid_out);
   cover property (mode_enter_in && !busy_out);
   cover property (tx_valid_out && !tx_ready_in);
endmodule

bind aucp_interp aucp_interp_props u_props (
   .sys_clk_in, .srst_in, .rx_byte_in, .rx_valid_in, .mode_enter_in, .tx_ready_in,
   .exec_valid_in, .tx_byte_out, .tx_valid_out, .req_valid_out, .busy_out);
`default_nettype wire

// [bench/aucp_exec_model.sv]
// Executor stand-in answering interpreter requests with status and values
`timescale 1ns/1ps
`default_nettype none
module aucp_exec_model
   import aucp_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire logic [3:0] status_in,
   input wire logic [3:0] delay_in,
   input wire logic [7:0][7:0] vals_in,
   input wire logic [3:0] vals_len_in,
   input wire logic val_ready_in,
   output logic exec_valid_out,
   output aucp_exec_t exec_out,
   output logic [7:0] val_byte_out,
   output logic val_valid_out,
   output logic val_last_out
);
   logic pend_q;
   logic [3:0] wait_q;
   logic [3:0] idx_q;
   initial {exec_valid_out, val_valid_out, pend_q, val_byte_out} = '0;
   always @(posedge clk_in) begin
      if (rst_in) begin
         pend_q <= 1'b0;
         exec_valid_out <= 1'b0;
         val_valid_out <= 1'b0;
      end else begin
         exec_valid_out <= 1'b0;
         if (req_valid_in) begin
            pend_q <= 1'b1;
            wait_q <= delay_in;
         end else if (pend_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (pend_q) begin
            pend_q <= 1'b0;
            exec_valid_out <= 1'b1;
            exec_out <= '{status: status_in, has_vals: vals_len_in != 4'h0};
            idx_q <= 4'h0;
            val_valid_out <= vals_len_in != 4'h0;
            val_byte_out <= vals_in[0];
            val_last_out <= vals_len_in == 4'h1;
         end
         // Released line shows the inverse so a stale byte is never mistaken for data
         if (val_valid_out && val_ready_in) begin
            idx_q <= idx_q + 4'h1;
            val_valid_out <= !val_last_out;
            val_byte_out <= val_last_out ? ~val_byte_out : vals_in[idx_q + 4'h1];
            val_last_out <= (idx_q + 4'h2) == vals_len_in;
         end
      end
   end
endmodule
`default_nettype wire

// [bench/aucp_interp_tb_top.sv]
// Self-checking testbench for the ASCII command interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((exp) !== (got)) begin \
         $display("ERROR %s expected %0h seen %0h", what, exp, got); \
         miscompares++; \
      end \
   end
module aucp_interp_tb_top
   import aucp_pkg::*;
   ;
   logic sys_clk_in, srst_in, rx_valid_in, mode_enter_in, tx_ready_in;
   logic [7:0] rx_byte_in, tx_byte_out, val_byte, param_char;
   logic exec_valid, val_valid, val_last, val_ready, tx_valid_out, req_valid_out;
   logic param_valid, busy_out;
   logic [6:0] param_idx;
   logic [3:0] m_status, m_delay, m_len;
   logic [7:0][7:0] m_vals;
   aucp_exec_t exec;
   aucp_req_t req_out;
   int miscompares, samples_checked;
   int param_hits;
   logic [7:0] param_last;
   logic [6:0] param_last_idx;

   // Tallies parameter characters reported by the interpreter
   always @(posedge sys_clk_in) begin
      if (param_valid) begin
         param_hits <= param_hits + 1;
         param_last <= param_char;
         param_last_idx <= param_idx;
      end
   end

   aucp_interp u_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .rx_byte_in(rx_byte_in),
      .rx_valid_in(rx_valid_in), .mode_enter_in(mode_enter_in), .tx_ready_in(tx_ready_in),
      .exec_valid_in(exec_valid), .exec_in(exec), .val_byte_in(val_byte),
      .val_valid_in(val_valid), .val_last_in(val_last), .tx_byte_out(tx_byte_out),
      .tx_valid_out(tx_valid_out), .val_ready_out(val_ready), .req_valid_out(req_valid_out),
      .req_out(req_out), .param_char_out(param_char), .param_idx_out(param_idx),
      .param_valid_out(param_valid), .busy_out(busy_out));

   aucp_exec_model u_exec (.clk_in(sys_clk_in), .rst_in(srst_in), .req_valid_in(req_valid_out),
      .status_in(m_status), .delay_in(m_delay), .vals_in(m_vals), .vals_len_in(m_len),
      .val_ready_in(val_ready), .exec_valid_out(exec_valid), .exec_out(exec),
      .val_byte_out(val_byte), .val_valid_out(val_valid), .val_last_out(val_last));

   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end

   function automatic logic [7:0] crc8(string s);
      logic [7:0] c;
      c = 8'hFF;
      foreach (s[i]) begin
         c = c ^ s[i];
         repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   // Appends optional blanks, decimal checksum and CR
   function automatic string seal(string s, string gap = "");
      return {s, gap, $sformatf("%0d", crc8(s)), "\r"};
   endfunction

   task automatic results();
      $display("Compared %0d values, %0d mismatches", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic step();
      @(posedge sys_clk_in);
      #1;
   endtask

   task automatic send(string s);
      foreach (s[i]) begin
         rx_valid_in = 1'b1;
         rx_byte_in = s[i];
         step();
      end
      rx_valid_in = 1'b0;
      rx_byte_in = ~rx_byte_in;
   endtask

   task automatic set_vals(string s);
      m_len = 4'(s.len());
      foreach (s[i]) m_vals[i] = s[i];
   endtask

   // Stall toggles ready every cycle so bytes must hold across refusals
   task automatic expect_resp(string exp, bit stall);
      int n;
      n = 0;
      foreach (exp[i]) begin
         while (tx_valid_out !== 1'b1 || tx_ready_in !== 1'b1) begin
            step();
            n++;
            if (stall) tx_ready_in = ~tx_ready_in;
            if (n > 400) begin
               `CHK("response wait", 1'b0, 1'b1)
               results();
            end
         end
         `CHK("tx byte", exp[i], tx_byte_out)
         step();
         // Refuse every further byte once so holding is exercised
         if (stall && (i + 1 < exp.len())) tx_ready_in = 1'b0;
      end
      tx_ready_in = 1'b1;
      `CHK("busy after response", 1'b0, busy_out)
   endtask

   task automatic t_ack();
      mode_enter_in = 1'b1;
      step();
      mode_enter_in = 1'b0;
      expect_resp(seal("#CMDMODE,"), 1'b0);
   endtask

   task automatic t_status_codes();
      string nm;
      `CHK("line checksum", 8'h1C, crc8("$isn,"))
      for (int s = 0; s <= 8; s++) begin
         m_status = 4'(s);
         nm = "isn";
         if (s inside {[1:3]}) nm = "";
         send(seal("$isn,", " \t"));
         `CHK("request pulse", 1'b1, req_valid_out)
         `CHK("name first char", 8'h69, req_out.name[0])
         `CHK("name length", 4'h3, req_out.name_len)
         `CHK("param count", 7'h00, req_out.param_cnt)
         expect_resp(seal($sformatf("#%s,%0d,", nm, s)), s[0]);
      end
   endtask

   task automatic t_framing_errors();
      string b;
      b = "$sbto,0.00123,";
      send({b, $sformatf("%0d", crc8(b) + 8'h01), "\r"});
      `CHK("request on bad checksum", 1'b0, req_valid_out)
      expect_resp(seal("#,2,"), 1'b0);
      send("ibto,160\r");
      expect_resp("#,1,180\r", 1'b0);
      m_status = 4'h0;
      send(seal("$Isn,"));
      `CHK("name flag", 1'b1, req_out.name_bad)
      expect_resp(seal("#,3,"), 1'b0);
   endtask

   task automatic t_lowest_code();
      m_status = 4'h4;
      send(seal("$sbto,,"));
      expect_resp(seal("#sbto,4,"), 1'b0);
      m_status = 4'h7;
      send(seal("$save,a%,"));
      expect_resp(seal("#save,5,"), 1'b0);
   endtask

   task automatic t_values();
      string d;
      d = $sformatf("%0d", crc8("$sdbto,-1.5e+2,0.0083,"));
      set_vals("-0.1,0.1");
      m_status = 4'h8;
      param_hits = 0;
      send(seal("$sdbto,-1.5e+2,0.0083,"));
      `CHK("param count", 7'h02, req_out.param_cnt)
      `CHK("param chars", 13 + d.len(), param_hits)
      `CHK("last param char", d[d.len() - 1], param_last)
      `CHK("last param index", 7'h02, param_last_idx)
      expect_resp(seal("#sdbto,8,-0.1,0.1,"), 1'b1);
      set_vals("0");
      m_status = 4'h6;
      send(seal("$save,"));
      expect_resp(seal("#save,6,0,"), 1'b0);
      set_vals("");
   endtask

   // Overlong line then a line of exactly the maximum length
   task automatic t_length();
      string junk, b, s, gap;
      junk = "$isn";
      repeat (96) junk = {junk, "a"};
      b = "$isn,";
      repeat (89) b = {b, "a"};
      b = {b, ","};
      s = $sformatf("%0d", crc8(b));
      gap = "";
      // Blanks before the checksum pad the line to exactly the limit
      repeat (4 - s.len()) gap = {gap, " "};
      s = seal(b, gap);
      m_status = 4'h0;
      send({junk, s});
      `CHK("line length", 100, s.len())
      `CHK("request after long line", 1'b1, req_valid_out)
      `CHK("param count", 7'h01, req_out.param_cnt)
      expect_resp(seal("#isn,0,"), 1'b0);
   endtask

   initial begin
      miscompares = 0;
      samples_checked = 0;
      srst_in = 1'b1;
      rx_valid_in = 1'b0;
      rx_byte_in = 8'h00;
      mode_enter_in = 1'b0;
      tx_ready_in = 1'b1;
      m_status = 4'h0;
      m_delay = 4'h2;
      m_len = 4'h0;
      m_vals = '0;
      repeat (4) @(posedge sys_clk_in);
      #1;
      srst_in = 1'b0;
      `CHK("idle after reset", 1'b0, busy_out)
      t_ack();
      t_status_codes();
      t_framing_errors();
      t_lowest_code();
      t_values();
      t_length();
      results();
   end
endmodule
`default_nettype wire
